// ===== restart_pkg.sv
// shared constants, register map and carriers for the fault restart sequencer
package restart_pkg;
    // ==========================================================
    // clock and time base
    localparam int unsigned CLK_HZ = 100_000_000;
    localparam int unsigned TICK_MS = 100;
    localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
    localparam int unsigned TICKS_PER_S = 1000 / TICK_MS;
    localparam int unsigned FAULT_FREE_MIN = 10;
    localparam logic [15:0] FAULT_FREE_TICKS =
        16'(FAULT_FREE_MIN * 60 * TICKS_PER_S);
    // ==========================================================
    // setting limits and reset values, times in 0.1 s steps
    localparam logic [3:0] LIMIT_MAX = 4'h a;
    localparam logic [3:0] LIMIT_RST = 4'h0;
    localparam logic [15:0] CONT_TIME_RST = 16'h0708;
    localparam logic [15:0] CONT_TIME_MAX = 16'h1770;
    localparam logic [15:0] INTV_TIME_RST = 16'h0064;
    localparam logic [15:0] INTV_TIME_MIN = 16'h0005;
    localparam logic [15:0] INTV_TIME_MAX = 16'h1770;
    localparam logic [15:0] BB_TIME_RST = 16'h0005;
    localparam logic FOUT_SEL_RST = 1'b0;
    localparam logic COUNT_MODE_RST = 1'b1;
    localparam logic [1:0] RIDE_RST = 2'h0;
    localparam logic [1:0] RIDE_ENABLED = 2'h1;
    localparam logic [7:0] DOUT_FN_FAULT = 8'h0e;
    localparam logic [7:0] DOUT_FN_RESTART = 8'h1e;
    localparam logic [7:0] DOUT_FN_RST = 8'h00;
    localparam int unsigned DOUT_N = 3;
    // ==========================================================
    // register byte addresses
    localparam logic [7:0] A_CONFIG = 8'h00;
    localparam logic [7:0] A_BB_TIME = 8'h04;
    localparam logic [7:0] A_CONT_TIME = 8'h08;
    localparam logic [7:0] A_INTV_TIME = 8'h0c;
    localparam logic [7:0] A_DOUT_FN = 8'h10;
    localparam logic [7:0] A_STATUS = 8'h14;
    localparam logic [7:0] A_COMMAND = 8'h18;
    localparam logic [7:0] A_INT_STAT = 8'h1c;
    localparam logic [7:0] A_INT_MASK = 8'h20;
    // ==========================================================
    // interrupt event bits
    localparam int unsigned EV_ATTEMPT = 0;
    localparam int unsigned EV_SUCCESS = 1;
    localparam int unsigned EV_LOCKOUT = 2;
    localparam int unsigned EV_CLEARED = 3;
    localparam int unsigned EV_N = 4;
    // ==========================================================
    // sequencer states
    typedef enum logic [2:0] {
        ST_RUN = 3'b000,
        ST_BLOCK = 3'b001,
        ST_CHECK = 3'b010,
        ST_SEARCH = 3'b011,
        ST_WAIT = 3'b100,
        ST_LOCK = 3'b101
    } seq_state_e;
    // restartable fault inputs from the protection logic
    typedef struct packed {
        logic ground_fault;
        logic output_open_phase;
        logic overcurrent_fault;
        logic drive_overheat_fault;
        logic motor_overload_fault;
        logic drive_overload_fault;
        logic overtorque_one_fault;
        logic overtorque_two_fault;
        logic bus_overvoltage_fault;
        logic input_phase_loss_fault;
        logic braking_resistor_fault;
        logic braking_transistor_fault;
        logic bus_undervoltage_fault;
        logic pull_out_fault;
    } fault_in_s;
    // software settings
    typedef struct packed {
        logic speed_search_select;
        logic [1:0] ride_through_select;
        logic restart_count_mode;
        logic restart_fault_output_select;
        logic [3:0] restart_limit;
    } config_s;
endpackage

// ===== tick_gen.sv
// enable pulse divider for the 0.1 s sequencer time base
`timescale 1ns/100ps
module tick_gen #(
    parameter int unsigned DIV = 10_000_000
) (
    input wire logic hclk,
    input wire logic hresetn,
    output logic tick
);
    localparam int unsigned W = $clog2(DIV + 1);
    localparam logic [W-1:0] LAST = W'(DIV - 1);
    logic [W-1:0] cnt_q;
    logic [W-1:0] cnt_d;
    logic tick_d;
    // ==========================================================
    // free running count, one pulse per wrap
    always_comb begin
        tick_d = (cnt_q == LAST);
        cnt_d = tick_d ? '0 : cnt_q + W'(1);
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_q <= '0;
            tick <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            tick <= tick_d;
        end
    end
endmodule // tick_gen

// ===== fault_auto_restart_sequencer.sv
// automatic fault restart sequencer with an ahb-lite register slave
// Behaviour
// - only listed restartable faults start restarts
// - restart limit zero to ten, zero disables
// - limit reached: stop, stay faulted until reset
// - ten fault-free minutes after restart clear count
// - manual reset in lockout or power loss clears count
// - baseblock, then check fault, restart if clear
// - restart always uses speed search from command
// - count real attempts, not blocked ones
// - success mode: fault after continue time elapses
// - fault output during restart selectable
// - output function 1e shows restart enabled
// - undervoltage restarts only with ride-through one
// - attempt mode waits interval between attempts
// - count mode selects successes or attempts
// - attempt mode stops once attempts reach limit
`timescale 1ns/100ps
module fault_auto_restart_sequencer #(
    parameter int unsigned TICK_DIV = restart_pkg::TICK_CYCLES
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire restart_pkg::fault_in_s faults,
    input wire logic other_fault,
    input wire logic restart_ok,
    input wire logic restart_fail,
    input wire logic reset_key,
    output logic baseblock,
    output logic search_start,
    output logic search_from_command,
    output logic fault_relay_output,
    output logic restart_enabled,
    output logic [restart_pkg::DOUT_N-1:0] digital_out,
    output logic irq
);
    // ==========================================================
    // declarations
    restart_pkg::config_s cfg_q, cfg_d;
    logic [15:0] bb_time_q, bb_time_d;
    logic [15:0] cont_time_q, cont_time_d;
    logic [15:0] intv_time_q, intv_time_d;
    logic [7:0] dout_fn_q [restart_pkg::DOUT_N];
    logic [7:0] dout_fn_d [restart_pkg::DOUT_N];
    logic [restart_pkg::EV_N-1:0] int_stat_q, int_stat_d;
    logic [restart_pkg::EV_N-1:0] int_mask_q, int_mask_d;
    logic [restart_pkg::EV_N-1:0] ev;
    logic [31:0] rdata_d;
    logic [7:0] waddr_q, waddr_d;
    logic wr_q, wr_d;
    logic man_reset;
    logic tick;
    restart_pkg::seq_state_e st_q, st_d;
    logic [3:0] count_q, count_d;
    logic [15:0] tmr_q, tmr_d;
    logic [15:0] cont_q, cont_d;
    logic [15:0] free_q, free_d;
    logic restarted_q, restarted_d;
    logic fault_seen_q;
    logic any_fault, fault_rise, restartable, search_pulse_d;
    logic [31:0] wdata;

    tick_gen #(.DIV(TICK_DIV)) u_tick (
        .hclk(hclk),
        .hresetn(hresetn),
        .tick(tick)
    );

    // ==========================================================
    // setting clamp, shared by the continue and interval time writes
    function automatic logic [15:0] clamp16(input logic [15:0] v,
                                            input logic [15:0] lo,
                                            input logic [15:0] hi);
        clamp16 = (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction

    // ==========================================================
    // fault qualification
    // undervoltage is only restartable with ride-through enabled
    always_comb begin
        any_fault = (|faults) | other_fault;
        fault_rise = any_fault & ~fault_seen_q;
        restartable = ~other_fault & (|faults) &
            (~faults.bus_undervoltage_fault |
             (cfg_q.ride_through_select == restart_pkg::RIDE_ENABLED));
    end

    // ==========================================================
    // ahb-lite slave: zero wait state, always okay
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign wdata = hwdata;

    always_comb begin
        wr_d = hsel & htrans[1] & hwrite & hready;
        waddr_d = haddr[7:0];
        rdata_d = hrdata;
        if (hsel & htrans[1] & hready & ~hwrite) begin
            rdata_d = 32'h0000_0000;
            case (haddr[7:0])
                restart_pkg::A_CONFIG: rdata_d[8:0] = cfg_q;
                restart_pkg::A_BB_TIME: rdata_d[15:0] = bb_time_q;
                restart_pkg::A_CONT_TIME: rdata_d[15:0] = cont_time_q;
                restart_pkg::A_INTV_TIME: rdata_d[15:0] = intv_time_q;
                restart_pkg::A_DOUT_FN:
                    rdata_d[23:0] = {dout_fn_q[2], dout_fn_q[1], dout_fn_q[0]};
                restart_pkg::A_STATUS:
                    rdata_d[9:0] = {fault_relay_output, restart_enabled,
                                    st_q, count_q, restarted_q};
                restart_pkg::A_INT_STAT: rdata_d[3:0] = int_stat_q;
                restart_pkg::A_INT_MASK: rdata_d[3:0] = int_mask_q;
                default: ;
            endcase
        end
    end

    // register writes land in the data phase
    always_comb begin
        cfg_d = cfg_q;
        bb_time_d = bb_time_q;
        cont_time_d = cont_time_q;
        intv_time_d = intv_time_q;
        int_mask_d = int_mask_q;
        dout_fn_d = dout_fn_q;
        man_reset = reset_key;
        // set wins over a same-cycle write-one clear
        int_stat_d = int_stat_q | ev;
        if (wr_q) begin
            case (waddr_q)
                restart_pkg::A_CONFIG: begin
                    cfg_d = wdata[8:0];
                    cfg_d.restart_limit = (wdata[3:0] > restart_pkg::LIMIT_MAX)
                        ? restart_pkg::LIMIT_MAX : wdata[3:0];
                end
                restart_pkg::A_BB_TIME: bb_time_d = wdata[15:0];
                restart_pkg::A_CONT_TIME:
                    cont_time_d = clamp16(wdata[15:0], 16'h0000,
                                          restart_pkg::CONT_TIME_MAX);
                restart_pkg::A_INTV_TIME:
                    intv_time_d = clamp16(wdata[15:0],
                                          restart_pkg::INTV_TIME_MIN,
                                          restart_pkg::INTV_TIME_MAX);
                restart_pkg::A_DOUT_FN: begin
                    dout_fn_d[0] = wdata[7:0];
                    dout_fn_d[1] = wdata[15:8];
                    dout_fn_d[2] = wdata[23:16];
                end
                restart_pkg::A_COMMAND: man_reset = reset_key | wdata[0];
                restart_pkg::A_INT_STAT:
                    int_stat_d = (int_stat_q & ~wdata[3:0]) | ev;
                restart_pkg::A_INT_MASK: int_mask_d = wdata[3:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cfg_q <= {1'b0, restart_pkg::RIDE_RST,
                      restart_pkg::COUNT_MODE_RST,
                      restart_pkg::FOUT_SEL_RST, restart_pkg::LIMIT_RST};
            bb_time_q <= restart_pkg::BB_TIME_RST;
            cont_time_q <= restart_pkg::CONT_TIME_RST;
            intv_time_q <= restart_pkg::INTV_TIME_RST;
            for (int i = 0; i < restart_pkg::DOUT_N; i++) begin
                dout_fn_q[i] <= restart_pkg::DOUT_FN_RST;
            end
            int_stat_q <= '0;
            int_mask_q <= '0;
            hrdata <= 32'h0000_0000;
            wr_q <= 1'b0;
            waddr_q <= 8'h00;
        end else begin
            cfg_q <= cfg_d;
            bb_time_q <= bb_time_d;
            cont_time_q <= cont_time_d;
            intv_time_q <= intv_time_d;
            dout_fn_q <= dout_fn_d;
            int_stat_q <= int_stat_d;
            int_mask_q <= int_mask_d;
            hrdata <= rdata_d;
            wr_q <= wr_d;
            waddr_q <= waddr_d;
        end
    end

    assign irq = |(int_stat_q & int_mask_q);

    // ==========================================================
    // restart sequencer
    // relies on the run wiring dropping so fault inputs fall after a trip
    always_comb begin
        st_d = st_q;
        count_d = count_q;
        tmr_d = tmr_q;
        cont_d = cont_q;
        free_d = free_q;
        restarted_d = restarted_q;
        search_pulse_d = 1'b0;
        ev = '0;
        // continue-restart window only runs in success counting mode
        if (st_q inside {restart_pkg::ST_BLOCK, restart_pkg::ST_CHECK,
                         restart_pkg::ST_SEARCH}
            && !cfg_q.restart_count_mode && tick) begin
            cont_d = cont_q + 16'h0001;
        end
        case (st_q)
            restart_pkg::ST_RUN: begin
                if (fault_rise) begin
                    free_d = 16'h0000;
                    tmr_d = 16'h0000;
                    cont_d = 16'h0000;
                    if (restartable && cfg_q.restart_limit != 4'h0
                        && count_q < cfg_q.restart_limit) begin
                        st_d = restart_pkg::ST_BLOCK;
                    end else begin
                        st_d = restart_pkg::ST_LOCK;
                        ev[restart_pkg::EV_LOCKOUT] = 1'b1;
                    end
                end else if (restarted_q && tick) begin
                    free_d = free_q + 16'h0001;
                    if (free_d >= restart_pkg::FAULT_FREE_TICKS) begin
                        count_d = 4'h0;
                        restarted_d = 1'b0;
                        ev[restart_pkg::EV_CLEARED] = 1'b1;
                    end
                end
            end
            restart_pkg::ST_BLOCK: begin
                if (tick) begin
                    tmr_d = tmr_q + 16'h0001;
                end
                if (tmr_q >= bb_time_q) begin
                    st_d = restart_pkg::ST_CHECK;
                end
            end
            restart_pkg::ST_CHECK: begin
                if (any_fault) begin
                    // blocked attempts are never counted
                    if (cfg_q.restart_count_mode) begin
                        tmr_d = 16'h0000;
                        st_d = restart_pkg::ST_WAIT;
                    end
                end else begin
                    search_pulse_d = 1'b1;
                    ev[restart_pkg::EV_ATTEMPT] = 1'b1;
                    if (cfg_q.restart_count_mode) begin
                        count_d = count_q + 4'h1;
                    end
                    st_d = restart_pkg::ST_SEARCH;
                end
            end
            restart_pkg::ST_SEARCH: begin
                if (restart_ok) begin
                    if (!cfg_q.restart_count_mode) begin
                        count_d = count_q + 4'h1;
                    end
                    restarted_d = 1'b1;
                    free_d = 16'h0000;
                    ev[restart_pkg::EV_SUCCESS] = 1'b1;
                    st_d = restart_pkg::ST_RUN;
                end else if (restart_fail || any_fault) begin
                    tmr_d = 16'h0000;
                    free_d = 16'h0000;
                    if (cfg_q.restart_count_mode
                        && count_q >= cfg_q.restart_limit) begin
                        st_d = restart_pkg::ST_LOCK;
                        ev[restart_pkg::EV_LOCKOUT] = 1'b1;
                    end else if (cfg_q.restart_count_mode) begin
                        st_d = restart_pkg::ST_WAIT;
                    end else begin
                        st_d = restart_pkg::ST_BLOCK;
                    end
                end
            end
            restart_pkg::ST_WAIT: begin
                if (tick) begin
                    tmr_d = tmr_q + 16'h0001;
                end
                if (tmr_q >= intv_time_q) begin
                    if (count_q >= cfg_q.restart_limit) begin
                        st_d = restart_pkg::ST_LOCK;
                        ev[restart_pkg::EV_LOCKOUT] = 1'b1;
                    end else begin
                        st_d = restart_pkg::ST_CHECK;
                    end
                end
            end
            restart_pkg::ST_LOCK: begin
                // stays tripped until a manual reset with no fault left
                if (man_reset && !any_fault) begin
                    count_d = 4'h0;
                    restarted_d = 1'b0;
                    ev[restart_pkg::EV_CLEARED] = 1'b1;
                    st_d = restart_pkg::ST_RUN;
                end
            end
            default: st_d = restart_pkg::ST_LOCK;
        endcase
        // success mode gives up once the window runs out
        if (!cfg_q.restart_count_mode && cont_d > cont_time_q
            && st_d inside {restart_pkg::ST_BLOCK, restart_pkg::ST_CHECK,
                            restart_pkg::ST_SEARCH}) begin
            st_d = restart_pkg::ST_LOCK;
            ev[restart_pkg::EV_LOCKOUT] = 1'b1;
        end
    end

    // power-up reset clears the count as a power cycle does
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_q <= restart_pkg::ST_RUN;
            count_q <= 4'h0;
            tmr_q <= 16'h0000;
            cont_q <= 16'h0000;
            free_q <= 16'h0000;
            restarted_q <= 1'b0;
            fault_seen_q <= 1'b0;
            search_start <= 1'b0;
        end else begin
            st_q <= st_d;
            count_q <= count_d;
            tmr_q <= tmr_d;
            cont_q <= cont_d;
            free_q <= free_d;
            restarted_q <= restarted_d;
            fault_seen_q <= any_fault;
            search_start <= search_pulse_d;
        end
    end

    // ==========================================================
    // drive-facing outputs, decoded from state
    always_comb begin
        baseblock = st_q inside {restart_pkg::ST_BLOCK, restart_pkg::ST_CHECK,
                                 restart_pkg::ST_WAIT, restart_pkg::ST_LOCK};
        restart_enabled = st_q inside {restart_pkg::ST_BLOCK,
            restart_pkg::ST_CHECK, restart_pkg::ST_SEARCH,
            restart_pkg::ST_WAIT};
        // speed search source ignores the selection in the search state only
        search_from_command = (st_q == restart_pkg::ST_SEARCH) ? 1'b1
            : cfg_q.speed_search_select;
        fault_relay_output = (st_q == restart_pkg::ST_LOCK) ||
            (restart_enabled && cfg_q.restart_fault_output_select);
    end

    // three configurable outputs
    generate
        for (genvar g = 0; g < restart_pkg::DOUT_N; g++) begin : g_dout
            assign digital_out[g] =
                (dout_fn_q[g] == restart_pkg::DOUT_FN_RESTART) ?
                    restart_enabled :
                (dout_fn_q[g] == restart_pkg::DOUT_FN_FAULT) ?
                    fault_relay_output : 1'b0;
        end
    endgenerate
endmodule // fault_auto_restart_sequencer

// ===== restart_props.sv
// port checker for the fault restart sequencer
`timescale 1ns/100ps
module restart_props (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire restart_pkg::fault_in_s faults,
    input wire logic other_fault,
    input wire logic reset_key,
    input wire logic baseblock,
    input wire logic search_start,
    input wire logic search_from_command,
    input wire logic fault_relay_output,
    input wire logic restart_enabled
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // ==========
    // command write flag, marks a manual clear
    logic cmd_q;
    logic cmd_d;
    always_comb cmd_d = hsel & htrans[1] & hwrite & (haddr[7:0] == 8'h18);
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) cmd_q <= 1'b0;
        else cmd_q <= cmd_d;
    end
    // ==========
    // state views built from the outputs alone
    sequence run_s;
        !restart_enabled && !baseblock;
    endsequence
    sequence lock_s;
        fault_relay_output && !restart_enabled;
    endsequence
    run_fault_a: assert property (run_s ##0 ($rose(|faults) ||
        $rose(other_fault)) |-> ##[1:2] baseblock) else $error("no trip");
    block_entry_a: assert property ($rose(restart_enabled) |-> baseblock)
        else $error("restart began without baseblock");
    search_clean_a: assert property (search_start |->
        $past(faults) == 14'h0 && !$past(other_fault)) else $error("dirty");
    search_pulse_a: assert property (search_start |=> !search_start)
        else $error("search start longer than one cycle");
    search_cmd_a: assert property (search_start |-> search_from_command)
        else $error("search not from command");
    restart_flag_a: assert property (search_start |-> restart_enabled)
        else $error("restart flag low during search");
    lock_block_a: assert property (lock_s |-> baseblock)
        else $error("output not blocked in lockout");
    lock_hold_a: assert property (lock_s ##0 (!reset_key && !cmd_q)
        |=> lock_s) else $error("unlock");
endmodule // restart_props
bind fault_auto_restart_sequencer restart_props i_props (.hclk, .hresetn,
    .hsel, .haddr, .htrans, .hwrite, .faults, .other_fault, .reset_key,
    .baseblock, .search_start, .search_from_command, .fault_relay_output,
    .restart_enabled);

// ===== motor_stage.sv
// power stage model answering speed search requests
`timescale 1ns/100ps
module motor_stage #(
    parameter int DELAY = 3
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic search_start,
    input wire logic succeed,
    output logic restart_ok,
    output logic restart_fail
);
    // ==========
    // answer a while after each search; idle low
    int cnt_q;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_q <= 0;
            restart_ok <= 1'b0;
            restart_fail <= 1'b0;
        end else begin
            cnt_q <= search_start ? DELAY : (cnt_q > 0 ? cnt_q - 1 : 0);
            restart_ok <= cnt_q == 1 && succeed;
            restart_fail <= cnt_q == 1 && !succeed;
        end
    end
endmodule // motor_stage

// ===== fault_auto_restart_sequencer_test.sv
// self-checking bench for the fault restart sequencer
`timescale 1ns/100ps
module fault_auto_restart_sequencer_test;
    // ==========
    // short tick keeps the ten minute wait affordable
    logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, irq;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic other_fault, restart_ok, restart_fail, reset_key, succeed;
    logic baseblock, search_start, search_from_command;
    logic fault_relay_output, restart_enabled;
    logic [restart_pkg::DOUT_N-1:0] digital_out;
    restart_pkg::fault_in_s faults;
    int failures, n_tests, seed, cnt, i, b, off;
    int rv[10] = '{'h20, 5, 'h708, 'h64, 0, 0, 0, 0, 0, 0};
    assign hready = hreadyout;
    fault_auto_restart_sequencer #(.TICK_DIV(10)) i_dut (.hclk, .hresetn,
        .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata,
        .hreadyout, .hresp, .faults, .other_fault, .restart_ok,
        .restart_fail, .reset_key, .baseblock, .search_start,
        .search_from_command, .irq, .fault_relay_output, .restart_enabled,
        .digital_out);
    motor_stage i_stage (.hclk, .hresetn, .succeed, .search_start,
        .restart_ok, .restart_fail);
    // ==========
    // shared tasks
    task automatic chk(input string nm, input logic [31:0] e, g);
        n_tests++;
        if (g !== e) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input int d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h00_0000, a};
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= 32'(d);
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
        chk("hresp", 0, 32'(hresp));
        #1;
    endtask
    task automatic count_is(input string nm, input int e);
        bus(0, 8'h14, 0);
        chk(nm, 32'(e), 32'(rd[4:1]));
    endtask
    // 0 search start, 1 lockout, 2 running; bounded so a hang shows
    task automatic wait_for(input int s);
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            #1;
            n++;
        end while (n < 3000 && !((s == 0 && search_start === 1'b1) ||
            (s == 1 && fault_relay_output === 1'b1 && restart_enabled === 1'b0)
            || (s == 2 && restart_enabled === 1'b0 && baseblock === 1'b0)));
        chk("wait", 0, 32'(n >= 3000));
    endtask
    // index 14 trips the non-restartable input
    task automatic trip(input int k);
        @(posedge hclk);
        faults <= (k < 14) ? restart_pkg::fault_in_s'(14'h1 << k) : '0;
        other_fault <= k == 14;
        @(posedge hclk);
        faults <= '0;
        other_fault <= 1'b0;
    endtask
    task automatic expect_restart();
        wait_for(0);
        chk("relay_out", 0, fault_relay_output);
        chk("dout", 3'h1, digital_out);
        cnt++;
        wait_for(2);
        count_is("count", cnt);
    endtask
    task automatic expect_lock();
        wait_for(1);
        chk("dout", 3'h2, digital_out);
        count_is("lock_count", cnt);
        @(posedge hclk);
        reset_key <= 1'b1;
        @(posedge hclk);
        reset_key <= 1'b0;
        cnt = 0;
        wait_for(2);
        count_is("clr_count", 0);
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end
    // hang guard
    initial begin
        repeat (80000) @(posedge hclk);
        failures++;
        print_verdict();
    end
    // ==========
    // main sequence
    initial begin
        {hresetn, hsel, hwrite, other_fault, reset_key, succeed} = '0;
        {haddr, hwdata, htrans, faults} = '0;
        hsize = 3'h2;
        {failures, n_tests, cnt} = '0;
        seed = 84821;
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        for (i = 0; i < 10; i++) begin
            bus(0, 8'(i * 4), 0);
            chk("reset_val", 32'(rv[i]), rd);
        end
        bus(1, 8'h00, 'h6f);
        bus(0, 8'h00, 0);
        chk("limit_clamp", 32'h0000_006a, rd);
        bus(1, 8'h0c, 1);
        bus(0, 8'h0c, 0);
        chk("intv_clamp", 5, rd);
        bus(1, 8'h04, 1);
        bus(1, 8'h10, 'he1e);
        $display("test registers done");
        // every restartable fault once, from a random start
        succeed <= 1'b1;
        off = {$random(seed)} % 14;
        for (i = 0; i < 14; i++) begin
            trip((i + off) % 14);
            if (cnt >= 10) expect_lock();
            else expect_restart();
        end
        bus(0, 8'h1c, 0);
        chk("int_stat", 32'h0000_000f, rd);
        chk("irq_masked", 0, 32'(irq));
        bus(1, 8'h20, 1);
        chk("irq_on", 1, 32'(irq));
        bus(1, 8'h1c, 'hf);
        chk("irq_off", 0, 32'(irq));
        $display("test fault list done");
        repeat (int'(restart_pkg::FAULT_FREE_TICKS) * 10 - 300) @(posedge hclk);
        count_is("early_count", cnt);
        repeat (400) @(posedge hclk);
        count_is("idle_count", 0);
        cnt = 0;
        $display("test fault free clear done");
        // failing attempts with the relay shown during restart
        succeed <= 1'b0;
        bus(1, 8'h00, 'h32);
        trip(13);
        for (i = 0; i < 2; i++) begin
            wait_for(0);
            chk("relay_on", 1, fault_relay_output);
            cnt++;
        end
        expect_lock();
        trip(1);
        expect_lock();
        trip(14);
        expect_lock();
        bus(1, 8'h08, 3);
        bus(1, 8'h00, 'h02);
        succeed <= 1'b1;
        trip(5);
        expect_restart();
        succeed <= 1'b0;
        trip(5);
        expect_lock();
        bus(1, 8'h00, 'h20);
        trip({$random(seed)} % 14);
        expect_lock();
        $display("test lockouts done");
        print_verdict();
    end
endmodule // fault_auto_restart_sequencer_test
